// >>> rtl/scs_defs.svh
// Constants of the conversion sequencer: codes, reset values and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ------------------------------------------------------------------------
// Code layout
// ------------------------------------------------------------------------
`define SCS_BITS          16
`define SCS_MSB_INDEX     4'hF
`define SCS_LSB_INDEX     4'h0
`define SCS_ZERO_CODE     16'h0000
`define SCS_CODE_MAX      16'h7FFF
`define SCS_CODE_MIN      16'h8000
`define SCS_SIGN_FLIP     16'h8000
`define SCS_RAW_ALL_HIGH  16'hFFFF
`define SCS_RAW_ALL_LOW   16'h0000
`define SCS_MSB_TRIAL     16'h8000

// ------------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------------
`define SCS_RESULT_RST    16'h0000
`define SCS_DAC_RST       16'h0000

// ------------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------------
`define SCS_CLOCK_HZ      40000000
`define SCS_SAMPLE_NS     1000
`define SCS_STEP_NS       50
// Least step time rounds up to whole cycles
`define SCS_STEP_CYCLES   ((`SCS_STEP_NS * (`SCS_CLOCK_HZ / 1000000) + 999) / 1000)

`endif

// >>> rtl/scs_pkg.sv
// Types shared by the conversion sequencer modules.
// Assumes scs_defs.svh is on the include path.
`include "scs_defs.svh"
`default_nettype none

package scs_pkg;

  typedef enum logic [1:0] {
    SCS_ACQUIRE = 2'b00,
    SCS_OPEN_SW = 2'b01,
    SCS_GROUND  = 2'b10,
    SCS_SEARCH  = 2'b11
  } scs_state_t;

  typedef struct packed {
    scs_state_t             state;
    logic [3:0]             bit_index;
    logic [`SCS_BITS-1:0]   dac;
    logic [`SCS_BITS-1:0]   result;
    logic                   sw_closed;
    logic                   array_to_inputs;
    logic                   array_to_ground;
    logic                   busy;
    logic                   done;
    logic                   power;
    logic                   trig_meta;
    logic                   trig_sync;
    logic                   trig_prev;
  } scs_seq_t;

endpackage

`default_nettype wire

// >>> rtl/scs_conv_clock.sv
// Internal conversion clock: a one-cycle step enable every DIV cycles.
// Assumes an asynchronous active-low reset already released on i_clock.
`include "scs_defs.svh"
`default_nettype none

module scs_conv_clock #(
  parameter int unsigned DIV = `SCS_STEP_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_tick
);

  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } scs_div_t;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  scs_div_t s_q;
  scs_div_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    // Restart the phase at every run so each conversion sees the same timing
    if (!i_run)
    begin
      s_d.count = 8'h00;
    end
    else if (s_q.count == LAST)
    begin
      s_d.count = 8'h00;
      s_d.tick  = 1'b1;
    end
    else
    begin
      s_d.count = s_q.count + 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

`default_nettype wire

// >>> rtl/scs_sequencer.sv
// Conversion control of one channel of a successive-approximation converter.
// Assumes a latched comparator strobed on i_clock, so its result is in domain;
// the trigger comes from a pin and is synchronised here.
//
// Overview of operation
// - Trigger rising edge ends acquisition, starts conversion
// - Open sample switches, then ground both arrays
// - MSB-first search over sixteen binary-weighted elements
// - After last bit: acquire, present code, flag done
// - Internal conversion clock; no serial shift clock needed
// - Result is sixteen-bit two's complement code
// - Overrange input saturates at 0x7FFF
// - Underrange input saturates at 0x8000
// - Up to 1 MSPS; power down between conversions
// - Result belongs to the conversion just completed
// - Started conversion always runs to completion
`include "scs_defs.svh"
`default_nettype none

module scs_sequencer #(
  parameter int unsigned STEP_DIV = `SCS_STEP_CYCLES
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_conversion_trigger,
  input  wire logic                 i_comparator,
  output logic                      o_positive_sample_switch,
  output logic                      o_negative_sample_switch,
  output logic                      o_array_to_inputs,
  output logic                      o_array_to_ground,
  output logic [`SCS_BITS-1:0]      o_element_to_reference,
  output logic                      o_power_up,
  output logic                      o_busy,
  output logic                      o_done,
  output logic [`SCS_BITS-1:0]      o_result
);

  // ------------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------------------
  // Conversion clock
  // ------------------------------------------------------------------------
  scs_pkg::scs_seq_t s_q;
  scs_pkg::scs_seq_t s_d;
  logic              step;
  logic              running;

  assign running = (s_q.state != scs_pkg::SCS_ACQUIRE);

  // Steps come only from this divider; the serial clock plays no part
  scs_conv_clock #(
    .DIV     (STEP_DIV)
  ) u_conv_clock (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .i_run   (running),
    .o_tick  (step)
  );

  // ------------------------------------------------------------------------
  // Code forming
  // ------------------------------------------------------------------------
  logic [`SCS_BITS-1:0] raw_final;
  logic [`SCS_BITS-1:0] code_final;
  logic                 trig_rise;

  // Final raw code with the LSB decision applied
  always_comb
  begin
    raw_final    = s_q.dac;
    raw_final[0] = i_comparator;
  end

  // Offset binary to two's complement; extremes pinned explicitly so that a
  // future change of the search cannot wrap an out-of-range input
  always_comb
  begin
    if (raw_final == `SCS_RAW_ALL_HIGH)
    begin
      code_final = `SCS_CODE_MAX;
    end
    else if (raw_final == `SCS_RAW_ALL_LOW)
    begin
      code_final = `SCS_CODE_MIN;
    end
    else
    begin
      code_final = raw_final ^ `SCS_SIGN_FLIP;
    end
  end

  assign trig_rise = s_q.trig_sync && !s_q.trig_prev;

  // ------------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------------
  always_comb
  begin
    s_d           = s_q;
    s_d.done      = 1'b0;
    s_d.trig_meta = i_conversion_trigger;
    s_d.trig_sync = s_q.trig_meta;
    s_d.trig_prev = s_q.trig_sync;
    case (s_q.state)
      scs_pkg::SCS_ACQUIRE:
      begin
        if (trig_rise)
        begin
          s_d.state     = scs_pkg::SCS_OPEN_SW;
          s_d.sw_closed = 1'b0;
          s_d.busy      = 1'b1;
          s_d.power     = 1'b1;
        end
      end
      scs_pkg::SCS_OPEN_SW:
      begin
        // Arrays leave the inputs only a step after the switches open
        if (step)
        begin
          s_d.state           = scs_pkg::SCS_GROUND;
          s_d.array_to_inputs = 1'b0;
          s_d.array_to_ground = 1'b1;
        end
      end
      scs_pkg::SCS_GROUND:
      begin
        if (step)
        begin
          s_d.state     = scs_pkg::SCS_SEARCH;
          s_d.dac       = `SCS_MSB_TRIAL;
          s_d.bit_index = `SCS_MSB_INDEX;
        end
      end
      scs_pkg::SCS_SEARCH:
      begin
        // Trigger level is not looked at here, so a conversion always ends
        if (step)
        begin
          s_d.dac[s_q.bit_index] = i_comparator;
          if (s_q.bit_index == `SCS_LSB_INDEX)
          begin
            s_d.state           = scs_pkg::SCS_ACQUIRE;
            s_d.result          = code_final;
            s_d.done            = 1'b1;
            s_d.busy            = 1'b0;
            s_d.power           = 1'b0;
            s_d.sw_closed       = 1'b1;
            s_d.array_to_inputs = 1'b1;
            s_d.array_to_ground = 1'b0;
            s_d.dac             = `SCS_DAC_RST;
          end
          else
          begin
            s_d.dac[s_q.bit_index - 4'h1] = 1'b1;
            s_d.bit_index                 = s_q.bit_index - 4'h1;
          end
        end
      end
      default:
      begin
        s_d.state = scs_pkg::SCS_ACQUIRE;
      end
    endcase
    // Edges seen outside acquisition are dropped, not queued
    if (running)
    begin
      s_d.trig_prev = s_q.trig_sync;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q                 <= '0;
      s_q.state           <= scs_pkg::SCS_ACQUIRE;
      s_q.sw_closed       <= 1'b1;
      s_q.array_to_inputs <= 1'b1;
      s_q.dac             <= `SCS_DAC_RST;
      s_q.result          <= `SCS_RESULT_RST;
      // Of the trigger stages only trig_prev is preset; a trigger already high at release still reads as an edge once it reaches trig_sync
      s_q.trig_prev       <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------------
  assign o_positive_sample_switch = s_q.sw_closed;
  assign o_negative_sample_switch = s_q.sw_closed;
  assign o_array_to_inputs        = s_q.array_to_inputs;
  assign o_array_to_ground        = s_q.array_to_ground;
  assign o_element_to_reference   = s_q.dac;
  assign o_power_up               = s_q.power;
  assign o_busy                   = s_q.busy;
  assign o_done                   = s_q.done;
  assign o_result                 = s_q.result;

endmodule

`default_nettype wire

// >>> verification/scs_sequencer_checker.sv
// Port-level assertions for the conversion sequencer.
// Assumes a bind from the bench and the design's step parameter handed on.
`include "scs_defs.svh"
`default_nettype none

module scs_sequencer_checker #(
  parameter int unsigned STEP_DIV = `SCS_STEP_CYCLES
) (
  input wire logic                 i_clock,
  input wire logic                 i_rst_n,
  input wire logic                 i_conversion_trigger,
  input wire logic                 i_comparator,
  input wire logic                 o_positive_sample_switch,
  input wire logic                 o_negative_sample_switch,
  input wire logic                 o_array_to_inputs,
  input wire logic                 o_array_to_ground,
  input wire logic [`SCS_BITS-1:0] o_element_to_reference,
  input wire logic                 o_power_up,
  input wire logic                 o_busy,
  input wire logic                 o_done,
  input wire logic [`SCS_BITS-1:0] o_result
);
  // The step enable is registered, so every phase lands one cycle after its step count
  localparam int GND_AT = STEP_DIV + 1;
  localparam int MSB_AT = 2 * STEP_DIV + 1;
  localparam int DONE_AT = 18 * STEP_DIV + 1;
  localparam int LAST = DONE_AT;
  logic [7:0] busy_cnt_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_cnt_q <= 8'h00;
    else if (!o_busy)
      busy_cnt_q <= 8'h00;
    else
      busy_cnt_q <= busy_cnt_q + 8'h01;
  end

  property p_start;
    $rose(o_busy) |-> !o_positive_sample_switch && !o_negative_sample_switch && o_array_to_inputs;
  endproperty
  a_start: assert property (p_start) else $error("switches not opened first");
  property p_ground;
    $rose(o_busy) |-> ##GND_AT o_array_to_ground && !o_array_to_inputs;
  endproperty
  a_ground: assert property (p_ground) else $error("arrays not grounded in time");
  property p_msb;
    $rose(o_busy) |-> ##MSB_AT o_element_to_reference == 16'h8000;
  endproperty
  a_msb: assert property (p_msb) else $error("search does not begin at top bit");
  property p_done_time;
    $rose(o_busy) |-> ##DONE_AT o_done;
  endproperty
  a_done_time: assert property (p_done_time) else $error("done late or early");
  property p_done_end;
    o_done |-> !o_busy && o_positive_sample_switch && o_array_to_inputs && !o_array_to_ground;
  endproperty
  a_done_end: assert property (p_done_end) else $error("not back in acquisition");
  property p_pulse;
    o_done |=> !o_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done wider than a cycle");
  property p_hold;
    !o_done |-> $stable(o_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without done");
  property p_power;
    o_power_up == o_busy;
  endproperty
  a_power: assert property (p_power) else $error("power not tied to conversion");
  property p_length;
    o_done |-> busy_cnt_q == LAST;
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  c_done: cover property (o_done);
  c_top: cover property (o_done ##1 o_result == 16'h7FFF);
  c_bottom: cover property (o_done ##1 o_result == 16'h8000);
  c_retrig: cover property (o_busy && $rose(i_conversion_trigger));
endmodule

`default_nettype wire

// >>> verification/scs_front_end.sv
// Analog front end model: holds the sample and compares it with the trial code.
// Assumes the sampling switch output of the sequencer marks acquisition.
`default_nettype none

module scs_front_end (
  input wire logic        i_clock,
  input wire logic        i_sample_switch,
  input wire logic [15:0] i_element,
  input wire logic [15:0] i_target,
  output logic            o_comparator
);
  logic [15:0] held_q;
  logic        flip_q = 1'b0;

  // Track while switches are closed, freeze once opened
  always_ff @(posedge i_clock)
  begin
    flip_q <= ~flip_q;
    if (i_sample_switch)
      held_q <= i_target;
  end

  // Outside a conversion the comparator output is meaningless: keep it moving
  assign o_comparator = i_sample_switch ? flip_q : (held_q >= i_element);
endmodule

`default_nettype wire

// >>> verification/scs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer with the front end model.
// Assumes the design and checker files are compiled before this one.
`default_nettype none

module scs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        trig = 1'b0;
  logic [15:0] target = 16'h0000;
  wire         cmp, psw, nsw, ain, agnd, pwr, busy, done;
  wire  [15:0] elem, res;
  int          miscompares = 0;
  int          tests_run = 0;
  int          len;
  localparam int unsigned STEP = 2;

  always #12.5 i_clock = ~i_clock;

  scs_sequencer #(.STEP_DIV(STEP)) u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_conversion_trigger(trig), .i_comparator(cmp), .o_positive_sample_switch(psw),
    .o_negative_sample_switch(nsw), .o_array_to_inputs(ain), .o_array_to_ground(agnd),
    .o_element_to_reference(elem), .o_power_up(pwr), .o_busy(busy), .o_done(done),
    .o_result(res));
  scs_front_end u_afe (.i_clock(i_clock), .i_sample_switch(psw), .i_element(elem),
    .i_target(target), .o_comparator(cmp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  // Trigger, then count cycles from busy to done
  task automatic convert(input logic [15:0] raw);
    int n;
    target = raw;
    step(1);
    trig = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    trig = 1'b0;
    len = 0;
    while (done !== 1'b1 && len < 100)
    begin
      step(1);
      len++;
    end
  endtask

  task automatic t_reset;
    check({9'h0, psw, nsw, ain, agnd, pwr, busy, done}, 16'h0070);
    check(res, 16'h0000);
  endtask

  task automatic t_codes;
    logic [15:0] raws [6] = '{16'h8000, 16'h8001, 16'h7FFF, 16'hFFFF, 16'h0000, 16'h0001};
    foreach (raws[i])
    begin
      convert(raws[i]);
      check(res, raws[i] ^ 16'h8000);
      // Registered step enable adds one cycle to the step count
      check(16'(len), 16'(18 * STEP + 1));
      check({12'h0, psw, ain, agnd, pwr}, 16'h000C);
    end
  endtask

  // Edges during conversion are ignored and the input change is not seen
  task automatic t_retrig;
    int dones;
    convert(16'h1234);
    dones = 0;
    target = 16'h9000;
    trig = 1'b1;
    for (int i = 0; i < 70; i++)
    begin
      step(1);
      if (busy === 1'b1 && target == 16'h9000)
        target = 16'hABCD;
      trig = (i < 34) ? i[2] : 1'b0;
      dones += int'(done === 1'b1);
    end
    check(res, 16'h1000);
    check(16'(dones), 16'd1);
    trig = 1'b1;
    dones = 0;
    repeat (80)
    begin
      step(1);
      dones += int'(done === 1'b1);
    end
    check(16'(dones), 16'd1);
    trig = 1'b0;
    step(4);
  endtask

  task automatic results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    step(8);
    t_reset();
    i_rst_n = 1'b1;
    step(6);
    t_codes();
    t_retrig();
    results();
  end

  initial
  begin
    #(3000 * 25);
    miscompares++;
    results();
  end
endmodule

bind scs_sequencer scs_sequencer_checker #(.STEP_DIV(STEP_DIV)) u_chk (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_conversion_trigger(i_conversion_trigger), .i_comparator(i_comparator),
  .o_positive_sample_switch(o_positive_sample_switch), .o_power_up(o_power_up),
  .o_negative_sample_switch(o_negative_sample_switch), .o_array_to_inputs(o_array_to_inputs),
  .o_array_to_ground(o_array_to_ground), .o_element_to_reference(o_element_to_reference),
  .o_busy(o_busy), .o_done(o_done), .o_result(o_result));

`default_nettype wire
